//--- logic/scsc_top.sv
// System clock source control: registers, source select and clock enables.
// Assumes oscillator running and clock-edge inputs come asynchronously from analogue cells.
`timescale 1ns/1ps
`default_nettype none
module scsc_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_high_osc_run,
    input  wire logic        ext_low_osc_run,
    input  wire logic        high_rc_run,
    input  wire logic        low_rc_run,
    input  wire logic        ext_high_clk,
    input  wire logic        ext_low_clk,
    input  wire logic        high_rc_clock,
    input  wire logic        low_rc_clock,
    output logic             ext_osc_enable,
    output logic             int_high_rc_enable,
    output logic             wdt_tick,
    output logic             osc_tick,
    output logic             cpu_tick,
    output logic [1:0]       active_source_state
);
    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for run levels and source clocks
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] sync3_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            // Internal RCs read as running so their ready flags survive release
            sync1_ff <= scsc_pkg::RST_RUN_SYNC;
            sync2_ff <= scsc_pkg::RST_RUN_SYNC;
            sync3_ff <= 8'h00;
        end else begin
            sync1_ff <= {ext_high_osc_run, ext_low_osc_run, high_rc_run, low_rc_run,
                         ext_high_clk, ext_low_clk, high_rc_clock, low_rc_clock};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    // Rising edges of synchronised source clocks; sources faster than mclk/2 alias
    logic [3:0] edge_w;
    assign edge_w = sync2_ff[3:0] & ~sync3_ff[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic       ext_en_ff;
    logic       hrc_en_ff;
    logic [1:0] select_ff;
    logic [1:0] prescale_ff;
    logic [7:0] divider_ff;
    logic [7:0] ext_cfg_ff;
    logic       ack_ff;
    logic [31:0] rdat_ff;
    logic       wr_w;
    assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && wb_sel_i[0];
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_en_ff   <= 1'b0;
            hrc_en_ff   <= 1'b1;
            select_ff   <= scsc_pkg::RST_SELECT;
            prescale_ff <= scsc_pkg::RST_PRESCALE;
            divider_ff  <= scsc_pkg::RST_DIVIDER;
            ext_cfg_ff  <= scsc_pkg::RST_EXT_CFG;
        end else if (wr_w) begin
            case (wb_adr_i)
                scsc_pkg::ADR_CONTROL: begin
                    // Flags and reserved bits ignore writes
                    ext_en_ff <= wb_dat_i[scsc_pkg::BIT_EXT_EN];
                    hrc_en_ff <= wb_dat_i[scsc_pkg::BIT_HIGH_RC_EN];
                end
                scsc_pkg::ADR_SWITCH: begin
                    select_ff   <= wb_dat_i[5:4];
                    prescale_ff <= wb_dat_i[1:0];
                end
                scsc_pkg::ADR_DIVIDER:    divider_ff <= wb_dat_i[7:0];
                scsc_pkg::ADR_EXT_CONFIG: ext_cfg_ff <= wb_dat_i[7:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready flags: fall at once on disable or loss, rise after warmup
    logic [3:0] rdy_ff;
    logic [3:0] run_w;
    assign run_w = {sync2_ff[7] & ext_en_ff & ~ext_cfg_ff[scsc_pkg::BIT_EXT_SEL],
                    sync2_ff[6] & ext_en_ff &  ext_cfg_ff[scsc_pkg::BIT_EXT_SEL],
                    sync2_ff[5] & hrc_en_ff, sync2_ff[4]};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rdy
            logic [7:0] warm_ff;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    warm_ff    <= 8'h00;
                    rdy_ff[gi] <= (gi >= 2) ? 1'b0 : 1'b1;
                end else if (!run_w[gi]) begin
                    warm_ff    <= 8'h00;
                    rdy_ff[gi] <= 1'b0;
                end else if (!rdy_ff[gi]) begin
                    if (warm_ff >= scsc_pkg::WARM_CYC - 8'h01) begin
                        rdy_ff[gi] <= 1'b1;
                    end else begin
                        warm_ff <= warm_ff + 8'h01;
                    end
                end
            end
        end
    endgenerate
    // Internal RC flags start ready: the reset value above is for gi 0,1 only
    logic [7:0] control_w;
    assign control_w = {rdy_ff[3], rdy_ff[2], rdy_ff[1], rdy_ff[0], 1'b0,
                        ext_en_ff, hrc_en_ff, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Source switch: only a ready source is accepted
    function automatic logic src_ready(input logic [1:0] s, input logic [3:0] r);
        case (s)
            scsc_pkg::SRC_LOW_RC:   src_ready = r[0];
            scsc_pkg::SRC_HIGH_RC:  src_ready = r[1];
            scsc_pkg::SRC_EXT_LOW:  src_ready = r[2];
            default:                src_ready = r[3];
        endcase
    endfunction : src_ready
    logic [1:0] state_ff;
    logic [1:0] req_src_w;
    // Select 1x routes the external oscillator chosen by its config bit
    assign req_src_w = select_ff[1] ? (ext_cfg_ff[scsc_pkg::BIT_EXT_SEL] ?
                       scsc_pkg::SRC_EXT_LOW : scsc_pkg::SRC_EXT_HIGH) : select_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= scsc_pkg::SRC_HIGH_RC;
        end else if (src_ready(req_src_w, {rdy_ff[3], rdy_ff[2], rdy_ff[1], rdy_ff[0]})) begin
            state_ff <= req_src_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator tick: high RC through prescaler, others direct
    logic [2:0] pre_ff;
    logic       pre_tick_w;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pre_ff <= 3'h0;
        end else if (edge_w[1]) begin
            pre_ff <= pre_ff + 3'h1;
        end
    end
    always_comb begin
        case (prescale_ff)
            2'h0:    pre_tick_w = edge_w[1];
            2'h1:    pre_tick_w = edge_w[1] & pre_ff[0];
            2'h2:    pre_tick_w = edge_w[1] & (&pre_ff[1:0]);
            default: pre_tick_w = edge_w[1] & (&pre_ff);
        endcase
    end
    logic osc_ff;
    logic wdt_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_ff <= 1'b0;
            wdt_ff <= 1'b0;
        end else begin
            wdt_ff <= edge_w[0];
            case (state_ff)
                scsc_pkg::SRC_LOW_RC:  osc_ff <= edge_w[0];
                scsc_pkg::SRC_HIGH_RC: osc_ff <= pre_tick_w;
                scsc_pkg::SRC_EXT_LOW: osc_ff <= edge_w[2];
                default:               osc_ff <= edge_w[3];
            endcase
        end
    end
    logic cpu_w;
    scsc_divider u_div (
        .mclk     (mclk),
        .rst      (rst),
        .tick_in  (osc_ff),
        .ratio    (divider_ff),
        .tick_out (cpu_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-wait-state ack, unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff  <= wb_cyc_i && wb_stb_i && !ack_ff;
            case (wb_adr_i)
                scsc_pkg::ADR_CONTROL:    rdat_ff <= {24'h000000, control_w};
                scsc_pkg::ADR_SWITCH:     rdat_ff <= {24'h000000, state_ff, select_ff,
                                                      2'h0, prescale_ff};
                scsc_pkg::ADR_DIVIDER:    rdat_ff <= {24'h000000, divider_ff};
                scsc_pkg::ADR_EXT_CONFIG: rdat_ff <= {24'h000000, ext_cfg_ff};
                default:                  rdat_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops
    logic cpu_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_ff <= 1'b0;
        end else begin
            cpu_ff <= cpu_w;
        end
    end
    assign ext_osc_enable      = ext_en_ff;
    assign int_high_rc_enable  = hrc_en_ff;
    assign wdt_tick            = wdt_ff;
    assign osc_tick            = osc_ff;
    assign cpu_tick            = cpu_ff;
    assign active_source_state = state_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ext_en_reset_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> !ext_osc_enable)
        else $error("ext enable not clear after reset");
    hrc_en_reset_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> int_high_rc_enable)
        else $error("high rc enable not set after reset");
    state_reset_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> active_source_state == scsc_pkg::SRC_HIGH_RC)
        else $error("source state wrong after reset");
    cfg_reset_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> divider_ff == scsc_pkg::RST_DIVIDER && prescale_ff == scsc_pkg::RST_PRESCALE)
        else $error("divider or prescale wrong after reset");
    int_rdy_reset_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> rdy_ff[1] && rdy_ff[0])
        else $error("internal ready flags clear after reset");
    ext_rdy_reset_a: assert property (
        @(posedge mclk)
        $fell(rst) |-> !rdy_ff[3] && !rdy_ff[2])
        else $error("external ready flags set after reset");
    rdy_drop_a: assert property (
        @(posedge mclk) disable iff (rst)
        !hrc_en_ff |=> !rdy_ff[1])
        else $error("ready flag stayed with oscillator disabled");
    ext_rdy_drop_a: assert property (
        @(posedge mclk) disable iff (rst)
        !ext_en_ff |=> !rdy_ff[3] && !rdy_ff[2])
        else $error("external ready stayed with oscillator off");
    ext_low_drop_a: assert property (
        @(posedge mclk) disable iff (rst)
        !run_w[2] |=> !rdy_ff[2])
        else $error("ext low ready stayed without run");
    hrc_warm_a: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(rdy_ff[1]) |-> $past(run_w[1], 10))
        else $error("high rc ready before warmup");
    ext_warm_a: assert property (
        @(posedge mclk) disable iff (rst)
        $rose(rdy_ff[3]) |-> $past(run_w[3], 10))
        else $error("ext high ready before warmup");
    ext_route_a: assert property (
        @(posedge mclk) disable iff (rst)
        rdy_ff[3] |-> !$past(ext_cfg_ff[scsc_pkg::BIT_EXT_SEL]))
        else $error("ext high ready while ext low configured");
    low_route_a: assert property (
        @(posedge mclk) disable iff (rst)
        rdy_ff[2] |-> $past(ext_cfg_ff[scsc_pkg::BIT_EXT_SEL]))
        else $error("ext low ready while ext high configured");
    rsv_zero_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_ack_o && !wb_we_i && $past(wb_adr_i) == scsc_pkg::ADR_CONTROL
            |-> wb_dat_o[3] == 1'b0 && wb_dat_o[0] == 1'b0)
        else $error("reserved control bit nonzero");
    en_write_a: assert property (
        @(posedge mclk) disable iff (rst)
        wr_w && wb_adr_i == scsc_pkg::ADR_CONTROL
            |=> ext_osc_enable == $past(wb_dat_i[scsc_pkg::BIT_EXT_EN])
            && int_high_rc_enable == $past(wb_dat_i[scsc_pkg::BIT_HIGH_RC_EN]))
        else $error("enable bits not written");
    lane_off_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0]
            |=> $stable(divider_ff) && $stable(ext_cfg_ff))
        else $error("write with lane off took effect");
    switch_ready_a: assert property (
        @(posedge mclk) disable iff (rst)
        $changed(state_ff) |-> $past(src_ready(req_src_w, rdy_ff)))
        else $error("switched to unready source");
    state_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        !src_ready(req_src_w, rdy_ff) |=> $stable(active_source_state))
        else $error("state moved to unready source");
    state_follow_a: assert property (
        @(posedge mclk) disable iff (rst)
        src_ready(req_src_w, rdy_ff) |=> active_source_state == $past(req_src_w))
        else $error("state did not follow ready request");
    osc_ext_high_a: assert property (
        @(posedge mclk) disable iff (rst)
        active_source_state == scsc_pkg::SRC_EXT_HIGH && edge_w[3] |=> osc_tick)
        else $error("ext high edge not passed");
    osc_ext_low_a: assert property (
        @(posedge mclk) disable iff (rst)
        active_source_state == scsc_pkg::SRC_EXT_LOW && edge_w[2] |=> osc_tick)
        else $error("ext low edge not passed");
    osc_low_rc_a: assert property (
        @(posedge mclk) disable iff (rst)
        active_source_state == scsc_pkg::SRC_LOW_RC && edge_w[0] |=> osc_tick)
        else $error("low rc edge not passed");
    pre_bypass_a: assert property (
        @(posedge mclk) disable iff (rst)
        active_source_state == scsc_pkg::SRC_HIGH_RC && prescale_ff == 2'h0 && edge_w[1]
            |=> osc_tick)
        else $error("undivided high rc edge not passed");
    osc_quiet_a: assert property (
        @(posedge mclk) disable iff (rst)
        edge_w == 4'h0 |=> !osc_tick)
        else $error("oscillator tick without source edge");
    div_pass_a: assert property (
        @(posedge mclk) disable iff (rst)
        (osc_ff && divider_ff <= 8'h01 && $stable(divider_ff)) |=> ##1 cpu_tick)
        else $error("undivided clock tick lost");
    cpu_slow_a: assert property (
        @(posedge mclk) disable iff (rst)
        cpu_tick && divider_ff == 8'h04 && $stable(divider_ff) |=> !cpu_tick [*3])
        else $error("cpu tick faster than ratio");
    cpu_from_osc_a: assert property (
        @(posedge mclk) disable iff (rst)
        cpu_tick |-> $past(osc_tick, 2))
        else $error("cpu tick without oscillator tick");
    wdt_follow_a: assert property (
        @(posedge mclk) disable iff (rst)
        edge_w[0] |=> wdt_tick)
        else $error("watchdog tick missing");
    ack_once_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_answer_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    dat_upper_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data nonzero");
    sw_cov: cover property (@(posedge mclk) $changed(state_ff));
    wr_cov: cover property (@(posedge mclk) wr_w && wb_adr_i == scsc_pkg::ADR_CONTROL);
    rdy_cov: cover property (@(posedge mclk) $rose(rdy_ff[3]));
    div4_cov: cover property (@(posedge mclk) cpu_tick && divider_ff == 8'h04);
    ext_low_cov: cover property (@(posedge mclk) active_source_state == scsc_pkg::SRC_EXT_LOW);
endmodule : scsc_top
`default_nettype wire

//--- logic/scsc_pkg.sv
// Package of constants for the system clock source control block.
// Assumes a classic Wishbone slave with 8-bit registers in the low byte of 32-bit words.
// Overview of operation
// - External high 4-24 MHz and external low 32.768 kHz sources are selectable.
// - Internal high RC 32 MHz and internal low RC 44 kHz are candidates.
// - Oscillator clock divided by any integer 1-255 gives the processor clock.
// - Internal high RC may be prescaled by 1, 2, 4 or 8.
// - Internal low RC clocks the watchdog and can be system clock.
// - External oscillator config picks high or low external oscillator.
// - After reset oscillator clock is 4 MHz, processor clock 2 MHz.
// - Control bit 7 is read-only external high oscillator ready flag.
// - Control bit 6 is read-only external low oscillator ready flag.
// - Control bit 5 is read-only internal high RC ready, one after reset.
// - Control bit 4 is read-only internal low RC ready, one after reset.
// - Control bit 2 enables external oscillator, cleared at reset.
// - Control bit 1 keeps internal high RC running, set at reset.
// - Prescale field 00/01/10/11 divides by 1/2/4/8, default 11.
// - Divider resets to 2; 0 and 1 pass undivided; else ratio.
// - Select 00 low RC, 01 high RC; unready source keeps previous clock.
// - State field reports active source: 00,01,10,11.
package scsc_pkg;
    localparam logic [3:0] ADR_CONTROL     = 4'h0;
    localparam logic [3:0] ADR_SWITCH      = 4'h1;
    localparam logic [3:0] ADR_DIVIDER     = 4'h2;
    localparam logic [3:0] ADR_EXT_CONFIG  = 4'h3;
    localparam logic [3:0] ADR_STATUS_OSC  = 4'h4;
    localparam int BIT_EXT_HIGH_RDY  = 7;
    localparam int BIT_EXT_LOW_RDY   = 6;
    localparam int BIT_HIGH_RC_RDY   = 5;
    localparam int BIT_LOW_RC_RDY    = 4;
    localparam int BIT_EXT_EN        = 2;
    localparam int BIT_HIGH_RC_EN    = 1;
    localparam int BIT_EXT_SEL       = 0;
    localparam logic [1:0] RST_PRESCALE  = 2'h3;
    localparam logic [1:0] RST_SELECT    = 2'h1;
    localparam logic [7:0] RST_DIVIDER   = 8'h02;
    localparam logic [7:0] RST_EXT_CFG   = 8'h00;
    localparam logic [7:0] RST_RUN_SYNC  = 8'h30;
    localparam logic [1:0] SRC_LOW_RC    = 2'h0;
    localparam logic [1:0] SRC_HIGH_RC   = 2'h1;
    localparam logic [1:0] SRC_EXT_LOW   = 2'h2;
    localparam logic [1:0] SRC_EXT_HIGH  = 2'h3;
    // Warmup spent after an oscillator enable before its ready flag rises
    localparam int  WARM_NS     = 1000;
    localparam int  CLK_NS      = 100;
    localparam logic [7:0] WARM_CYC = 8'(((WARM_NS + CLK_NS - 1) / CLK_NS));
endpackage : scsc_pkg

//--- logic/scsc_divider.sv
// Integer clock-enable divider for the processor clock.
// Assumes the oscillator tick arrives as a one-cycle enable pulse on mclk.
`timescale 1ns/1ps
`default_nettype none
module scsc_divider (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       tick_in,
    input  wire logic [7:0] ratio,
    output logic            tick_out
);
    logic [7:0] cnt_ff;
    logic       out_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= 8'h00;
            out_ff <= 1'b0;
        end else begin
            out_ff <= 1'b0;
            if (tick_in) begin
                // Ratios 0 and 1 pass every tick
                if (ratio <= 8'h01 || cnt_ff >= ratio - 8'h01) begin
                    cnt_ff <= 8'h00;
                    out_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 8'h01;
                end
            end
        end
    end
    assign tick_out = out_ff;
endmodule : scsc_divider
`default_nettype wire

//--- tb/scsc_osc_model.sv
// Behavioural oscillator cells on the far side of the clock source control.
// Assumes enables come from the block; a stopped cell's clock stands low.
`timescale 1ns/1ps
`default_nettype none
module scsc_osc_model (
    input  wire logic ext_osc_enable,
    input  wire logic int_high_rc_enable,
    input  wire logic low_fitted,
    output logic      ext_high_osc_run,
    output logic      ext_low_osc_run,
    output logic      high_rc_run,
    output logic      low_rc_run,
    output logic      ext_high_clk,
    output logic      ext_low_clk,
    output logic      high_rc_clock,
    output logic      low_rc_clock
);
    // One external cell: the fitted part decides which side runs
    assign ext_high_osc_run = ext_osc_enable & ~low_fitted;
    assign ext_low_osc_run  = ext_osc_enable & low_fitted;
    assign high_rc_run      = int_high_rc_enable;
    assign low_rc_run       = 1'b1;
    // Periods scaled to whole mclk multiples so tick spacing is exact
    initial begin
        high_rc_clock = 1'b0;
        #37;
        forever begin
            #200 high_rc_clock = high_rc_run ? ~high_rc_clock : 1'b0;
        end
    end
    initial begin
        low_rc_clock = 1'b0;
        #41;
        forever begin
            #400 low_rc_clock = ~low_rc_clock;
        end
    end
    initial begin
        ext_high_clk = 1'b0;
        #43;
        forever begin
            #300 ext_high_clk = ext_high_osc_run ? ~ext_high_clk : 1'b0;
        end
    end
    initial begin
        ext_low_clk = 1'b0;
        #47;
        forever begin
            #500 ext_low_clk = ext_low_osc_run ? ~ext_low_clk : 1'b0;
        end
    end
endmodule : scsc_osc_model
`default_nettype wire

//--- tb/system_clock_source_control_bench.sv
// Self-checking bench: Wishbone register accesses and tick spacing checks.
// Assumes the oscillator model drives all analogue-side inputs.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_control_bench;
    logic        mclk, rst, cyc, stb, we, ack, low_fitted;
    logic [3:0]  adr, sel;
    logic [31:0] dat_i, dat_o, q;
    logic        ext_en, hrc_en, wdt_t, osc_t, cpu_t;
    logic        eh_run, el_run, h_run, l_run, eh_clk, el_clk, h_clk, l_clk;
    logic [1:0]  state;
    int          failures, total_checks;
    int          dv[6] = '{0, 1, 2, 3, 4, 255};

    scsc_top i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ext_high_osc_run(eh_run), .ext_low_osc_run(el_run), .high_rc_run(h_run),
        .low_rc_run(l_run), .ext_high_clk(eh_clk), .ext_low_clk(el_clk),
        .high_rc_clock(h_clk), .low_rc_clock(l_clk), .ext_osc_enable(ext_en),
        .int_high_rc_enable(hrc_en), .wdt_tick(wdt_t), .osc_tick(osc_t), .cpu_tick(cpu_t),
        .active_source_state(state));
    scsc_osc_model i_osc (.ext_osc_enable(ext_en), .int_high_rc_enable(hrc_en),
        .low_fitted(low_fitted), .ext_high_osc_run(eh_run), .ext_low_osc_run(el_run),
        .high_rc_run(h_run), .low_rc_run(l_run), .ext_high_clk(eh_clk),
        .ext_low_clk(el_clk), .high_rc_clock(h_clk), .low_rc_clock(l_clk));

    ////////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_i <= {24'h000000, d};
        // Only the watchdog ends a wait for ack
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
        wb(1'b0, a, 4'hF, 8'h00);
        check(nm, q, {24'h000000, e});
    endtask : rdc

    function automatic logic pick(input int s);
        return (s == 0) ? osc_t : (s == 1) ? cpu_t : wdt_t;
    endfunction : pick

    // Skips two intervals so a ratio change never lands in the measured one
    task gapc(input int s, input int e, input string nm);
        int c;
        repeat (3) begin
            c = 0;
            do begin
                @(posedge mclk);
                c++;
            end while (pick(s) !== 1'b1 && c < 3000);
        end
        check(nm, c, e);
    endtask : gapc

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        #3000000;
        failures++;
        $display("watchdog expired");
        results;
    end

    initial begin
        {rst, cyc, stb, we, low_fitted} = 5'b10000;
        {adr, sel, dat_i} = '0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rdc(scsc_pkg::ADR_CONTROL, 8'h32, "control reset");
        rdc(scsc_pkg::ADR_SWITCH, 8'h53, "switch reset");
        rdc(scsc_pkg::ADR_DIVIDER, 8'h02, "divider reset");
        rdc(scsc_pkg::ADR_EXT_CONFIG, 8'h00, "ext config reset");
        rdc(4'hF, 8'h00, "unmapped read");
        check("state port", state, 2'h1);
        gapc(0, 32, "osc gap reset");
        gapc(1, 64, "cpu gap reset");
        gapc(2, 8, "wdt gap");
        $display("test reset done");
        wb(1'b1, scsc_pkg::ADR_CONTROL, 4'hF, 8'hFF);
        rdc(scsc_pkg::ADR_CONTROL, 8'h36, "control write all");
        check("ext enable port", ext_en, 1'b1);
        repeat (20) @(posedge mclk);
        rdc(scsc_pkg::ADR_CONTROL, 8'hB6, "ext high ready");
        wb(1'b1, scsc_pkg::ADR_CONTROL, 4'hF, 8'h02);
        repeat (6) @(posedge mclk);
        rdc(scsc_pkg::ADR_CONTROL, 8'h32, "ext off");
        wb(1'b1, scsc_pkg::ADR_CONTROL, 4'hF, 8'h00);
        repeat (6) @(posedge mclk);
        rdc(scsc_pkg::ADR_CONTROL, 8'h10, "high rc off");
        check("high rc enable port", hrc_en, 1'b0);
        wb(1'b1, scsc_pkg::ADR_CONTROL, 4'hF, 8'h02);
        rdc(scsc_pkg::ADR_CONTROL, 8'h12, "high rc warming");
        repeat (20) @(posedge mclk);
        rdc(scsc_pkg::ADR_CONTROL, 8'h32, "high rc ready");
        $display("test control done");
        // Ends on prescale 1 so the divider gaps below stay short
        for (int p = 3; p >= 0; p--) begin
            wb(1'b1, scsc_pkg::ADR_SWITCH, 4'hF, 8'(8'h10 | p));
            gapc(0, 4 << p, "osc gap prescale");
        end
        foreach (dv[i]) begin
            wb(1'b1, scsc_pkg::ADR_DIVIDER, 4'hF, 8'(dv[i]));
            gapc(1, 4 * ((dv[i] < 2) ? 1 : dv[i]), "cpu gap divider");
        end
        wb(1'b1, scsc_pkg::ADR_DIVIDER, 4'hE, 8'h07);
        rdc(scsc_pkg::ADR_DIVIDER, 8'hFF, "divider lane off");
        $display("test dividers done");
        wb(1'b1, scsc_pkg::ADR_SWITCH, 4'hF, 8'h00);
        repeat (3) @(posedge mclk);
        rdc(scsc_pkg::ADR_SWITCH, 8'h00, "switch to low rc");
        gapc(0, 8, "osc gap low rc");
        wb(1'b1, scsc_pkg::ADR_SWITCH, 4'hF, 8'h20);
        repeat (5) @(posedge mclk);
        rdc(scsc_pkg::ADR_SWITCH, 8'h20, "unready ext held");
        wb(1'b1, scsc_pkg::ADR_CONTROL, 4'hF, 8'h06);
        repeat (20) @(posedge mclk);
        rdc(scsc_pkg::ADR_SWITCH, 8'hE0, "switch to ext high");
        check("state port ext", state, 2'h3);
        gapc(0, 6, "osc gap ext high");
        wb(1'b1, scsc_pkg::ADR_EXT_CONFIG, 4'hF, 8'h01);
        repeat (5) @(posedge mclk);
        rdc(scsc_pkg::ADR_SWITCH, 8'hE0, "unready ext low held");
        low_fitted <= 1'b1;
        repeat (25) @(posedge mclk);
        rdc(scsc_pkg::ADR_SWITCH, 8'hA0, "switch to ext low");
        gapc(0, 10, "osc gap ext low");
        rdc(scsc_pkg::ADR_CONTROL, 8'h76, "ext low ready");
        $display("test switching done");
        results;
    end
endmodule : system_clock_source_control_bench
`default_nettype wire
